// ==== design/runtime_settings_cmd_decoder.sv ====
// Decoder for bytes 5 to 8 of the run-time settings command and the state they control.
`timescale 1ns/1ps
module runtime_settings_cmd_decoder
  import rtsc_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  output logic cmd_ready_out,
  output logic resp_valid_out,
  output logic [7:0] resp_byte_out,
  output logic resp_last_out,
  input wire logic resp_ready_in,
  output logic cmd_done_out,
  output logic gp_cfg_load_out,
  output logic [1:0] adc_ref_level_out,
  output logic adc_ref_use_module_out,
  output logic edge_rise_en_out,
  output logic edge_fall_en_out,
  output logic edge_flag_out,
  input wire logic intr_detect_pin_in,
  output logic [2:0] general_pin_zero_role_out,
  output logic general_pin_zero_dir_input_out,
  output logic general_pin_zero_set_level_out,
  input wire logic usb_suspend_indicator_in,
  input wire logic receive_activity_led_in,
  input wire logic general_pin_zero_in,
  output logic general_pin_zero_out,
  output logic general_pin_zero_oe_out,
  output logic general_pin_zero_level_out
);
  dec_state_e state_q;
  dec_state_e state_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic match_q;
  logic match_d;
  logic [7:0] ref_byte_q;
  logic [7:0] ref_byte_d;
  logic [7:0] edge_byte_q;
  logic [7:0] edge_byte_d;
  logic [7:0] load_byte_q;
  logic [7:0] load_byte_d;
  logic [7:0] pin_byte_q;
  logic [7:0] pin_byte_d;
  logic [IDX_W-1:0] ridx_q;
  logic [IDX_W-1:0] ridx_d;
  logic [7:0] resp_q;
  logic [7:0] resp_d;
  logic done_q;
  logic done_d;
  logic load_q;
  logic load_d;
  logic commit;
  logic cmd_fire;
  logic resp_fire;

  logic [1:0] ref_lvl_q;
  logic [1:0] ref_lvl_d;
  logic src_q;
  logic src_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;
  logic flag_q;
  logic flag_d;
  logic [2:0] role_q;
  logic [2:0] role_d;
  logic dir_q;
  logic dir_d;
  logic lvl_q;
  logic lvl_d;

  logic intr_sync;
  logic intr_prev_q;
  logic intr_prev_d;
  logic rise_seen;
  logic fall_seen;
  logic edge_hit;
  logic flag_clear;

  logic pin_sync;
  logic pin_in_q;
  logic pin_in_d;
  logic pin_o_q;
  logic pin_o_d;
  logic pin_oe_q;
  logic pin_oe_d;

  level_sync u_intr_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(intr_detect_pin_in),
    .sync_out(intr_sync)
  );

  level_sync u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(general_pin_zero_in),
    .sync_out(pin_sync)
  );

  // Report reception and response streaming.
  assign cmd_ready_out = (state_q == ST_RECV);
  assign cmd_fire = cmd_valid_in && cmd_ready_out;
  assign resp_valid_out = (state_q == ST_RESP);
  assign resp_fire = resp_valid_out && resp_ready_in;
  assign resp_last_out = resp_valid_out && (ridx_q == IDX_LAST);
  assign commit = cmd_fire && (idx_q == IDX_LAST) && match_q;

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    match_d = match_q;
    ref_byte_d = ref_byte_q;
    edge_byte_d = edge_byte_q;
    load_byte_d = load_byte_q;
    pin_byte_d = pin_byte_q;
    ridx_d = ridx_q;
    resp_d = resp_q;
    done_d = 1'b0;
    case (state_q)
      ST_RECV: begin
        if (cmd_fire) begin
          idx_d = idx_q + 6'h01;
          case (idx_q)
            IDX_CODE: match_d = (cmd_byte_in == CMD_CODE);
            IDX_ADC_REF: ref_byte_d = cmd_byte_in;
            IDX_EDGE: edge_byte_d = cmd_byte_in;
            IDX_GP_LOAD: load_byte_d = cmd_byte_in;
            IDX_PIN_ZERO: pin_byte_d = cmd_byte_in;
            default: match_d = match_q;
          endcase
          if (commit) begin
            state_d = ST_RESP;
            ridx_d = IDX_CODE;
            resp_d = CMD_CODE;
            done_d = 1'b1;
          end
        end
      end
      ST_RESP: begin
        if (resp_fire) begin
          ridx_d = ridx_q + 6'h01;
          resp_d = (ridx_q == IDX_CODE) ? RESP_OK : RESP_FILL;
          if (ridx_q == IDX_LAST) begin
            state_d = ST_RECV;
            idx_d = IDX_CODE;
            match_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ST_RECV;
        idx_d = IDX_CODE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_RECV;
      idx_q <= IDX_CODE;
      match_q <= 1'b0;
      ref_byte_q <= RST_BYTE;
      edge_byte_q <= RST_BYTE;
      load_byte_q <= RST_BYTE;
      pin_byte_q <= RST_BYTE;
      ridx_q <= IDX_CODE;
      resp_q <= RST_BYTE;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      match_q <= match_d;
      ref_byte_q <= ref_byte_d;
      edge_byte_q <= edge_byte_d;
      load_byte_q <= load_byte_d;
      pin_byte_q <= pin_byte_d;
      ridx_q <= ridx_d;
      resp_q <= resp_d;
      done_q <= done_d;
    end
  end

  assign resp_byte_out = resp_q;
  assign cmd_done_out = done_q;

  // Run-time settings store, applied when the whole report has arrived.
  assign rise_seen = intr_sync && !intr_prev_q;
  assign fall_seen = !intr_sync && intr_prev_q;
  assign edge_hit = (rise_seen && rise_q) || (fall_seen && fall_q);
  assign flag_clear = commit && edge_byte_q[BIT_LOAD_EN] && edge_byte_q[BIT_FLAG_CLR];

  always_comb begin
    ref_lvl_d = ref_lvl_q;
    src_d = src_q;
    rise_d = rise_q;
    fall_d = fall_q;
    role_d = role_q;
    dir_d = dir_q;
    lvl_d = lvl_q;
    load_d = 1'b0;
    intr_prev_d = intr_sync;
    if (commit && ref_byte_q[BIT_LOAD_EN]) begin
      ref_lvl_d = ref_byte_q[BIT_REF_LVL_HI:BIT_REF_LVL_LO];
      src_d = ref_byte_q[BIT_REF_SRC];
    end
    if (commit && edge_byte_q[BIT_LOAD_EN]) begin
      if (edge_byte_q[BIT_RISE_MOD]) begin
        rise_d = edge_byte_q[BIT_RISE_VAL];
      end
      if (edge_byte_q[BIT_FALL_MOD]) begin
        fall_d = edge_byte_q[BIT_FALL_VAL];
      end
    end
    if (commit && (load_byte_q == GP_LOAD_YES)) begin
      load_d = 1'b1;
      role_d = pin_byte_q[BIT_ROLE_HI:BIT_ROLE_LO];
      dir_d = pin_byte_q[BIT_GP_DIR];
      lvl_d = pin_byte_q[BIT_GP_OUT];
    end
    if (edge_hit) begin
      flag_d = 1'b1;
    end else if (flag_clear) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ref_lvl_q <= RST_REF_LEVEL;
      src_q <= RST_REF_SRC;
      rise_q <= RST_RISE_EN;
      fall_q <= RST_FALL_EN;
      flag_q <= 1'b0;
      role_q <= RST_PIN_ROLE;
      dir_q <= RST_PIN_DIR;
      lvl_q <= RST_PIN_LEVEL;
      load_q <= 1'b0;
      intr_prev_q <= 1'b0;
    end else begin
      ref_lvl_q <= ref_lvl_d;
      src_q <= src_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      flag_q <= flag_d;
      role_q <= role_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
      load_q <= load_d;
      intr_prev_q <= intr_prev_d;
    end
  end

  assign adc_ref_level_out = ref_lvl_q;
  assign adc_ref_use_module_out = src_q;
  assign edge_rise_en_out = rise_q;
  assign edge_fall_en_out = fall_q;
  assign edge_flag_out = flag_q;
  assign general_pin_zero_role_out = role_q;
  assign general_pin_zero_dir_input_out = dir_q;
  assign general_pin_zero_set_level_out = lvl_q;
  assign gp_cfg_load_out = load_q;

  // Pin multiplexer for general pin zero.
  always_comb begin
    pin_in_d = pin_sync;
    pin_o_d = 1'b0;
    pin_oe_d = 1'b0;
    case (role_q)
      ROLE_GPIO: begin
        pin_oe_d = !dir_q;
        pin_o_d = lvl_q;
      end
      ROLE_SUSPEND: begin
        pin_oe_d = 1'b1;
        pin_o_d = usb_suspend_indicator_in;
      end
      ROLE_RX_LED: begin
        pin_oe_d = 1'b1;
        pin_o_d = receive_activity_led_in;
      end
      default: begin
        pin_oe_d = 1'b0;
        pin_o_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pin_in_q <= 1'b0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_in_q <= pin_in_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign general_pin_zero_out = pin_o_q;
  assign general_pin_zero_oe_out = pin_oe_q;
  assign general_pin_zero_level_out = pin_in_q;
endmodule

// ==== shared/rtsc_pkg.sv ====
// Constants for the run-time settings command decoder.
package rtsc_pkg;
  localparam logic [7:0] CMD_CODE = 8'h60;
  localparam logic [7:0] RESP_OK = 8'h00;
  localparam logic [7:0] RESP_FILL = 8'h00;
  localparam int REPORT_LEN = 64;
  localparam int IDX_W = 6;
  localparam logic [IDX_W-1:0] IDX_CODE = 6'h00;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ADC_REF = 6'h05;
  localparam logic [IDX_W-1:0] IDX_EDGE = 6'h06;
  localparam logic [IDX_W-1:0] IDX_GP_LOAD = 6'h07;
  localparam logic [IDX_W-1:0] IDX_PIN_ZERO = 6'h08;
  localparam logic [IDX_W-1:0] IDX_LAST = 6'h3f;
  localparam int BIT_LOAD_EN = 7;
  localparam int BIT_REF_LVL_HI = 2;
  localparam int BIT_REF_LVL_LO = 1;
  localparam int BIT_REF_SRC = 0;
  localparam int BIT_RISE_MOD = 4;
  localparam int BIT_RISE_VAL = 3;
  localparam int BIT_FALL_MOD = 2;
  localparam int BIT_FALL_VAL = 1;
  localparam int BIT_FLAG_CLR = 0;
  localparam int BIT_GP_OUT = 4;
  localparam int BIT_GP_DIR = 3;
  localparam int BIT_ROLE_HI = 2;
  localparam int BIT_ROLE_LO = 0;
  localparam logic [7:0] GP_LOAD_YES = 8'h01;
  localparam logic [1:0] REF_LVL_OFF = 2'h0;
  localparam logic [1:0] REF_LVL_LOW = 2'h1;
  localparam logic [1:0] REF_LVL_MID = 2'h2;
  localparam logic [1:0] REF_LVL_HIGH = 2'h3;
  localparam logic [2:0] ROLE_GPIO = 3'h0;
  localparam logic [2:0] ROLE_SUSPEND = 3'h1;
  localparam logic [2:0] ROLE_RX_LED = 3'h2;
  localparam logic [1:0] RST_REF_LEVEL = REF_LVL_OFF;
  localparam logic RST_REF_SRC = 1'b0;
  localparam logic RST_RISE_EN = 1'b0;
  localparam logic RST_FALL_EN = 1'b0;
  localparam logic [2:0] RST_PIN_ROLE = ROLE_GPIO;
  localparam logic RST_PIN_DIR = 1'b1;
  localparam logic RST_PIN_LEVEL = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  typedef enum logic [0:0] {
    ST_RECV,
    ST_RESP
  } dec_state_e;
endpackage

// ==== design/level_sync.sv ====
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module level_sync (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== tb/rtsc_chk.sv ====
// Checker of the run-time settings command decoder ports.
`timescale 1ns/1ps
module rtsc_chk (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic resp_ready_in,
  input wire logic resp_valid_out,
  input wire logic [7:0] resp_byte_out,
  input wire logic cmd_done_out,
  input wire logic gp_cfg_load_out,
  input wire logic [1:0] adc_ref_level_out,
  input wire logic adc_ref_use_module_out,
  input wire logic edge_rise_en_out,
  input wire logic edge_fall_en_out,
  input wire logic edge_flag_out,
  input wire logic [2:0] general_pin_zero_role_out,
  input wire logic general_pin_zero_dir_input_out,
  input wire logic general_pin_zero_set_level_out,
  input wire logic general_pin_zero_out,
  input wire logic general_pin_zero_oe_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_hold;
    resp_valid_out && !resp_ready_in |=> resp_valid_out && $stable(resp_byte_out);
  endproperty
  a_hold: assert property (p_hold) else $error("response byte not held");
  property p_status;
    resp_valid_out && resp_ready_in && resp_byte_out == 8'h60
      |=> resp_valid_out && resp_byte_out == 8'h00;
  endproperty
  a_status: assert property (p_status) else $error("bad second response byte");
  property p_echo; $rose(resp_valid_out) |-> cmd_done_out && resp_byte_out == 8'h60; endproperty
  a_echo: assert property (p_echo) else $error("bad first response byte");
  property p_adc;
    !cmd_done_out |-> $stable({adc_ref_level_out, adc_ref_use_module_out});
  endproperty
  a_adc: assert property (p_adc) else $error("reference changed alone");
  property p_edge; !cmd_done_out |-> $stable({edge_rise_en_out, edge_fall_en_out}); endproperty
  a_edge: assert property (p_edge) else $error("edge enables changed alone");
  property p_gp;
    !gp_cfg_load_out |-> $stable({general_pin_zero_role_out, general_pin_zero_dir_input_out,
      general_pin_zero_set_level_out});
  endproperty
  a_gp: assert property (p_gp) else $error("pin settings changed alone");
  property p_load; gp_cfg_load_out |-> cmd_done_out; endproperty
  a_load: assert property (p_load) else $error("pin load without command");
  property p_clr; $fell(edge_flag_out) |-> cmd_done_out; endproperty
  a_clr: assert property (p_clr) else $error("flag cleared without command");
  property p_set; $rose(edge_flag_out) |-> $past(edge_rise_en_out) || $past(edge_fall_en_out);
  endproperty
  a_set: assert property (p_set) else $error("flag set with edges off");
  property p_drive;
    general_pin_zero_oe_out && $past(general_pin_zero_role_out) == 3'h0
      |-> !$past(general_pin_zero_dir_input_out)
      && general_pin_zero_out == $past(general_pin_zero_set_level_out);
  endproperty
  a_drive: assert property (p_drive) else $error("pin drive mismatch");
endmodule
bind runtime_settings_cmd_decoder rtsc_chk u_chk (.*);

// ==== tb/host_model.sv ====
// Host model that sends command reports and takes the responses.
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk_in,
  input wire logic cmd_ready_in,
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_byte_in,
  input wire logic resp_last_in,
  output logic cmd_valid_out = 1'b0,
  output logic [7:0] cmd_byte_out = 8'h00,
  output logic resp_ready_out = 1'b0
);
  logic [7:0] rsp [64];
  int last_k;
  task automatic send(input logic [7:0] c, b5, b6, b7, b8);
    logic [7:0] v;
    for (int i = 0; i < 64; i++) begin
      v = i == 0 ? c : i == 5 ? b5 : i == 6 ? b6 : i == 7 ? b7 : i == 8 ? b8 : 8'h00;
      cmd_valid_out <= 1'b1;
      cmd_byte_out <= v;
      @(posedge sys_clk_in);
      while (!cmd_ready_in) @(posedge sys_clk_in);
    end
    cmd_valid_out <= 1'b0;
    cmd_byte_out <= ~v;
  endtask
  task automatic recv(input bit slow);
    last_k = -1;
    for (int k = 0; k < 64; k++) begin
      if (slow) begin
        resp_ready_out <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
      end
      resp_ready_out <= 1'b1;
      @(posedge sys_clk_in);
      while (!resp_valid_in) @(posedge sys_clk_in);
      rsp[k] = resp_byte_in;
      if (resp_last_in === 1'b1) last_k = k;
    end
    resp_ready_out <= 1'b0;
  endtask
endmodule

// ==== tb/runtime_settings_cmd_decoder_tb.sv ====
// Self-checking testbench of the run-time settings command decoder.
`timescale 1ns/1ps
module runtime_settings_cmd_decoder_tb;
  import rtsc_pkg::*;
  logic rst_n_in = 1'b0, intr_detect_pin_in = 1'b0, pin_ext = 1'b0;
  logic usb_suspend_indicator_in = 1'b0, receive_activity_led_in = 1'b0;
  logic sys_clk_in, cmd_valid_in, cmd_ready_out, resp_valid_out, resp_last_out, resp_ready_in;
  logic cmd_done_out, gp_cfg_load_out, adc_ref_use_module_out, edge_rise_en_out;
  logic edge_fall_en_out, edge_flag_out, general_pin_zero_in;
  logic general_pin_zero_dir_input_out, general_pin_zero_set_level_out;
  logic general_pin_zero_out, general_pin_zero_oe_out, general_pin_zero_level_out;
  logic [7:0] cmd_byte_in, resp_byte_out;
  logic [1:0] adc_ref_level_out;
  logic [2:0] general_pin_zero_role_out;
  int bad_count, num_checks, loads;
  assign general_pin_zero_in = general_pin_zero_oe_out ? general_pin_zero_out : pin_ext;
  runtime_settings_cmd_decoder u_dut (.*);
  host_model u_host (.sys_clk_in, .cmd_ready_in(cmd_ready_out), .resp_valid_in(resp_valid_out),
    .resp_byte_in(resp_byte_out), .cmd_valid_out(cmd_valid_in), .cmd_byte_out(cmd_byte_in),
    .resp_last_in(resp_last_out), .resp_ready_out(resp_ready_in));
  always @(posedge sys_clk_in) begin
    if (gp_cfg_load_out === 1'b1) loads <= loads + 1;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic cmd(input logic [7:0] b5, b6, b7, b8, input bit slow = 1'b0);
    u_host.send(CMD_CODE, b5, b6, b7, b8);
    u_host.recv(slow);
    chk("echo", 8'h60, u_host.rsp[0]);
    chk("status", 8'h00, u_host.rsp[1]);
    chk("last", 8'(REPORT_LEN - 1), 8'(u_host.last_k));
  endtask
  task automatic chk_adc(input logic [7:0] e);
    chk("adc", e, {5'h0, adc_ref_level_out, adc_ref_use_module_out});
  endtask
  task automatic chk_edge(input logic [7:0] e);
    chk("edge", e, {5'h0, edge_rise_en_out, edge_fall_en_out, edge_flag_out});
  endtask
  task automatic chk_pin(input logic [7:0] e);
    chk("pin", e, {6'h0, general_pin_zero_oe_out, general_pin_zero_out});
  endtask
  task automatic chk_gp(input logic [7:0] e);
    chk("gp", e, {3'h0, general_pin_zero_role_out, general_pin_zero_dir_input_out,
      general_pin_zero_set_level_out});
  endtask
  task automatic pin_edge(input logic v, input logic [7:0] e);
    intr_detect_pin_in <= v;
    tick(6);
    chk_edge(e);
  endtask
  task automatic do_reset;
    rst_n_in <= 1'b0;
    tick(6);
    rst_n_in <= 1'b1;
    tick(1);
  endtask
  task automatic t_defaults;
    chk_adc(8'h00);
    chk_edge(8'h00);
    chk_gp(8'h02);
    chk_pin(8'h00);
  endtask
  task automatic t_adc;
    for (int i = 0; i < 8; i++) begin
      cmd(8'h80 | 8'(i), 8'h00, 8'h00, 8'h00, i == 3);
      chk_adc(8'(i));
    end
    cmd(8'h7a, 8'h00, 8'h00, 8'h00);
    chk_adc(8'h07);
    u_host.send(8'h61, 8'h81, 8'h00, 8'h00, 8'h00);
    tick(4);
    chk("no answer", 8'h01, {6'h0, resp_valid_out, cmd_ready_out});
    chk_adc(8'h07);
  endtask
  task automatic t_edge;
    cmd(8'h00, 8'h98, 8'h00, 8'h00);
    chk_edge(8'h04);
    pin_edge(1'b1, 8'h05);
    pin_edge(1'b0, 8'h05);
    cmd(8'h00, 8'h17, 8'h00, 8'h00);
    chk_edge(8'h05);
    cmd(8'h00, 8'h81, 8'h00, 8'h00);
    chk_edge(8'h04);
    cmd(8'h00, 8'h86, 8'h00, 8'h00);
    chk_edge(8'h06);
    cmd(8'h00, 8'h92, 8'h00, 8'h00);
    chk_edge(8'h02);
    pin_edge(1'b1, 8'h02);
    pin_edge(1'b0, 8'h03);
    cmd(8'h00, 8'h80, 8'h00, 8'h00);
    chk_edge(8'h03);
  endtask
  task automatic t_gp;
    cmd(8'h00, 8'h00, 8'h01, 8'h10);
    tick(2);
    chk_gp(8'h01);
    chk_pin(8'h03);
    cmd(8'h00, 8'h00, 8'h02, 8'h0a);
    chk_pin(8'h03);
    chk("loads", 8'h01, 8'(loads));
    for (int r = 1; r < 3; r++) begin
      cmd(8'h00, 8'h00, 8'h01, 8'h08 | 8'(r));
      usb_suspend_indicator_in <= r == 1;
      receive_activity_led_in <= r == 2;
      tick(4);
      chk_pin(8'h03);
      usb_suspend_indicator_in <= r == 2;
      receive_activity_led_in <= r == 1;
      tick(4);
      chk_pin(8'h02);
    end
    cmd(8'h00, 8'h00, 8'h01, 8'h05);
    chk_pin(8'h00);
    cmd(8'h00, 8'h00, 8'h01, 8'h18);
    pin_ext <= 1'b1;
    tick(6);
    chk("pin in", 8'h01, {6'h0, general_pin_zero_oe_out, general_pin_zero_level_out});
    chk("loads", 8'h05, 8'(loads));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    do_reset;
    t_defaults;
    t_adc;
    t_edge;
    t_gp;
    do_reset;
    t_defaults;
    test_done;
  end
  initial begin
    #80000;
    bad_count++;
    test_done;
  end
endmodule
